// *** hw/adm_regs.sv ***
// identification, status and input selector registers of the converter
// assumes: a command decoder upstream turns serial register read and write
// commands into one-cycle requests on clock_in; analog monitors are asynchronous
`include "adm_consts.svh"

// Contract
// - the identification register is read-only, model code in bits 2:0, reserved bits 7:3.
// - the power-on flag in status bit 7 is set by every reset and cleared only by writing zero to it.
// - status bit 6 reads one while start-up is unfinished and zero once communication is possible.
// - status bits 5 to 2 are read-only flags, each one while its amplifier output is near a supply rail.
// - status bit 1 is set while the external reference is below a third of the analog supply span.
// - status bit 0 is set while the external reference is below 0.3 V and clear otherwise.
// - amplifier rail flags are reported only while the rail monitor enable is set.
// - both reference flags are gated by the two-bit reference monitor enable.
// - the status register sits at address 1 and resets to 80 hex.
// - the input selector sits at address 2, resets to 01 hex, positive code in 7:4 and negative in 3:0.
// - selector codes 0 to 11 pick analog inputs 0 to 11, code 12 the common input, others are reserved.
// - registers are reached by read and write commands and return to defaults on reset.
module adm_regs
    import adm_pkg::*;
#(
    parameter logic [2:0] MODEL_CODE    = 3'h6,  // arbitrary value
    parameter logic [4:0] RESERVED_BITS = 5'h00  // arbitrary value
) (
    input  wire logic                   clock_in,
    input  wire logic                   reset_n_in,
    // register command port
    input  wire logic                   cmd_valid_in,
    input  wire logic                   cmd_write_in,
    input  wire logic [`ADM_ADDR_W-1:0] cmd_addr_in,
    input  wire logic [7:0]             cmd_wdata_in,
    output logic                        rd_valid_out,
    output logic [7:0]                  rd_data_out,
    // analog monitor levels
    input  wire logic [3:0]             rail_near_in,
    input  wire logic                   ref_below_third_in,
    input  wire logic                   ref_missing_in,
    input  wire logic                   startup_done_in,
    // enables held by neighbouring registers
    input  wire logic                   rail_monitor_enable_in,
    input  wire logic [1:0]             ref_monitor_enable_in,
    // register contents towards the analog front end
    output logic                        power_on_event_flag_out,
    output logic [3:0]                  positive_input_select_out,
    output logic [3:0]                  negative_input_select_out,
    output logic [11:0]                 positive_ain_onehot_out,
    output logic                        positive_common_out,
    output logic                        positive_reserved_out,
    output logic [11:0]                 negative_ain_onehot_out,
    output logic                        negative_common_out,
    output logic                        negative_reserved_out
);

    ////////////////////////////////////////////////////////////////////////////
    // monitor front end

    adm_mon_if mon_bus ();

    adm_monitor_sync u_monitor (
        .clock_in               (clock_in),
        .reset_n_in             (reset_n_in),
        .rail_near_in           (rail_near_in),
        .ref_below_third_in     (ref_below_third_in),
        .ref_missing_in         (ref_missing_in),
        .startup_done_in        (startup_done_in),
        .rail_monitor_enable_in (rail_monitor_enable_in),
        .ref_monitor_enable_in  (ref_monitor_enable_in),
        .mon                    (mon_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // one selector field to one-hot input, common and reserved indications
    function automatic adm_sel_dec_s decode_sel(input logic [3:0] code);
        adm_sel_dec_s d;
        d = '0;
        if (code <= `ADM_LAST_AIN_CODE) begin
            d.ain_onehot = 12'h001 << code;
        end else if (code == `ADM_COMMON_CODE) begin
            d.common = 1'b1;
        end else begin
            d.reserved = 1'b1;
        end
        return d;
    endfunction : decode_sel

    // live view of the status register
    function automatic logic [7:0] status_view(input logic por, input logic not_ready,
                                               input logic [3:0] rail, input logic third,
                                               input logic missing);
        logic [7:0] v;
        v                                   = 8'h00;
        v[`ADM_POR_BIT]                     = por;
        v[`ADM_NOT_READY_BIT]               = not_ready;
        v[`ADM_RAIL_MSB:`ADM_RAIL_LSB]      = rail;
        v[`ADM_THIRD_BIT]                   = third;
        v[`ADM_MISSING_BIT]                 = missing;
        return v;
    endfunction : status_view

    ////////////////////////////////////////////////////////////////////////////
    // state

    // reset images held as sized constants so the reset branch needs no casts
    localparam logic [7:0] SEL_RESET = `ADM_SELECTOR_RESET;
    localparam logic [7:0] FLAGS_RST = `ADM_FLAGS_RESET;

    adm_bank_s  st;
    adm_bank_s  next_st;
    logic [7:0] identity_value;
    logic [7:0] status_value;
    logic       wr_req;
    logic       rd_req;

    always_comb begin
        identity_value                               = 8'h00;
        identity_value[`ADM_MODEL_MSB:`ADM_MODEL_LSB] = MODEL_CODE;
        identity_value[`ADM_RSVD_MSB:`ADM_RSVD_LSB]   = RESERVED_BITS;
    end

    // status word is assembled live; a read captures it at the request edge
    assign status_value = status_view(st.por_flag, mon_bus.not_ready, mon_bus.rail_flags,
                                      mon_bus.ref_below_third_flag, mon_bus.ref_missing_flag);
    assign wr_req = cmd_valid_in & cmd_write_in;
    assign rd_req = cmd_valid_in & ~cmd_write_in;

    always_comb begin
        next_st          = st;
        next_st.rd_valid = 1'b0;
        // writes: only the power-on flag and the selector can be changed
        if (wr_req) begin
            case (cmd_addr_in)
                `ADM_ADDR_FLAGS: begin
                    // a one written to the flag leaves it as it is; bits 6:0 ignored
                    next_st.por_flag = st.por_flag & cmd_wdata_in[`ADM_POR_BIT];
                end
                `ADM_ADDR_SELECTOR: begin
                    next_st.selector = cmd_wdata_in;
                end
                default: begin
                    // identification and unmapped addresses take no write
                    next_st.selector = st.selector;
                end
            endcase
        end
        // reads: answer one cycle after the request
        if (rd_req) begin
            next_st.rd_valid = 1'b1;
            case (cmd_addr_in)
                `ADM_ADDR_IDENTITY: next_st.rd_data = identity_value;
                `ADM_ADDR_FLAGS:    next_st.rd_data = status_value;
                `ADM_ADDR_SELECTOR: next_st.rd_data = st.selector;
                default:            next_st.rd_data = 8'h00;
            endcase
        end
        // decode the selector value that is about to be held
        next_st.pos_dec = decode_sel(next_st.selector[`ADM_POS_SEL_MSB:`ADM_POS_SEL_LSB]);
        next_st.neg_dec = decode_sel(next_st.selector[`ADM_NEG_SEL_MSB:`ADM_NEG_SEL_LSB]);
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            // every reset counts as a power-on event
            st          <= '0;
            st.por_flag <= FLAGS_RST[`ADM_POR_BIT];
            st.selector <= SEL_RESET;
            st.pos_dec  <= decode_sel(SEL_RESET[`ADM_POS_SEL_MSB:`ADM_POS_SEL_LSB]);
            st.neg_dec  <= decode_sel(SEL_RESET[`ADM_NEG_SEL_MSB:`ADM_NEG_SEL_LSB]);
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // everything towards host and front end comes straight from flops
    assign rd_valid_out              = st.rd_valid;
    assign rd_data_out               = st.rd_data;
    assign power_on_event_flag_out   = st.por_flag;
    assign positive_input_select_out = st.selector[`ADM_POS_SEL_MSB:`ADM_POS_SEL_LSB];
    assign negative_input_select_out = st.selector[`ADM_NEG_SEL_MSB:`ADM_NEG_SEL_LSB];
    assign positive_ain_onehot_out   = st.pos_dec.ain_onehot;
    assign positive_common_out       = st.pos_dec.common;
    assign positive_reserved_out     = st.pos_dec.reserved;
    assign negative_ain_onehot_out   = st.neg_dec.ain_onehot;
    assign negative_common_out       = st.neg_dec.common;
    assign negative_reserved_out     = st.neg_dec.reserved;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_por_after_reset:
    assert property (!$past(reset_n_in) |-> power_on_event_flag_out
                     && positive_input_select_out == 4'h0 && negative_input_select_out == 4'h1)
        else $error("defaults not present after reset release");

    a_por_cleared:
    assert property (wr_req && cmd_addr_in == `ADM_ADDR_FLAGS && !cmd_wdata_in[7]
                     |=> !power_on_event_flag_out)
        else $error("power-on flag not cleared by writing zero");

    a_por_stays_clear:
    assert property (!power_on_event_flag_out |=> !power_on_event_flag_out)
        else $error("power-on flag set without a reset");

    a_selector_write:
    assert property (wr_req && cmd_addr_in == `ADM_ADDR_SELECTOR
                     |=> {positive_input_select_out, negative_input_select_out} == $past(cmd_wdata_in))
        else $error("selector write not taken");

    a_ro_write_ignored:
    assert property (wr_req && cmd_addr_in != `ADM_ADDR_SELECTOR
                     |=> $stable({positive_input_select_out, negative_input_select_out}))
        else $error("selector changed by a write elsewhere");

    a_identity_read:
    assert property (rd_req && cmd_addr_in == `ADM_ADDR_IDENTITY
                     |=> rd_valid_out && rd_data_out == {RESERVED_BITS, MODEL_CODE})
        else $error("identification read wrong");

    a_status_read:
    assert property (rd_req && cmd_addr_in == `ADM_ADDR_FLAGS
                     |=> rd_valid_out && rd_data_out[6] == $past(mon_bus.not_ready)
                         && rd_data_out[7] == $past(power_on_event_flag_out)
                         && rd_data_out[5:2] == $past(mon_bus.rail_flags))
        else $error("status read does not match live flags");

    a_common_decode:
    assert property (positive_input_select_out == 4'hc
                     |-> positive_common_out && positive_ain_onehot_out == 12'h000 && !positive_reserved_out)
        else $error("common input code not decoded");

    a_ain_decode:
    assert property (negative_input_select_out <= 4'hb
                     |-> negative_ain_onehot_out == (12'h001 << negative_input_select_out)
                         && !negative_common_out)
        else $error("analog input code not decoded");

    a_read_pulse:
    assert property (rd_valid_out |-> $past(rd_req) ##1 !rd_valid_out || $past(rd_req, 1))
        else $error("read answer without request");

    ////////////////////////////////////////////////////////////////////////////
    // read answers carry what was held at the request edge

    a_status_low_read:
    assert property (rd_req && cmd_addr_in == `ADM_ADDR_FLAGS
                     |=> rd_data_out[1:0] == $past({mon_bus.ref_below_third_flag, mon_bus.ref_missing_flag}))
        else $error("reference flags wrong in status read");

    a_selector_read:
    assert property (rd_req && cmd_addr_in == `ADM_ADDR_SELECTOR
                     |=> rd_valid_out
                         && rd_data_out == $past({positive_input_select_out, negative_input_select_out}))
        else $error("selector read wrong");

    a_unmapped_read:
    assert property (rd_req && cmd_addr_in > `ADM_ADDR_SELECTOR |=> rd_valid_out && rd_data_out == 8'h00)
        else $error("unmapped read not answered with zero");

    a_read_answered:
    assert property (rd_req |=> rd_valid_out)
        else $error("read request not answered next cycle");

    // data stands until the next answer, so a slow host still sees it
    a_read_data_hold:
    assert property (!rd_valid_out |-> $stable(rd_data_out))
        else $error("read data moved without an answer");

    a_write_silent:
    assert property (wr_req |=> !rd_valid_out)
        else $error("write produced a read answer");

    ////////////////////////////////////////////////////////////////////////////
    // power-on flag: only a written zero clears it

    a_por_kept_by_one:
    assert property (wr_req && cmd_addr_in == `ADM_ADDR_FLAGS && cmd_wdata_in[`ADM_POR_BIT]
                     |=> $stable(power_on_event_flag_out))
        else $error("power-on flag changed by writing one");

    ////////////////////////////////////////////////////////////////////////////
    // selector decode: one of input, common or reserved per field

    a_pos_ain_decode:
    assert property (positive_input_select_out <= 4'hb
                     |-> positive_ain_onehot_out == (12'h001 << positive_input_select_out)
                         && !positive_common_out && !positive_reserved_out)
        else $error("positive analog input code not decoded");

    a_neg_common_decode:
    assert property (negative_input_select_out == 4'hc
                     |-> negative_common_out && negative_ain_onehot_out == 12'h000 && !negative_reserved_out)
        else $error("negative common input code not decoded");

    a_reserved_decode:
    assert property (positive_reserved_out == (positive_input_select_out > 4'hc)
                     && negative_reserved_out == (negative_input_select_out > 4'hc))
        else $error("reserved selector code not flagged");

    a_onehot_single:
    assert property ($onehot0(positive_ain_onehot_out) && $onehot0(negative_ain_onehot_out))
        else $error("more than one analog input selected");

endmodule : adm_regs

// *** hw/adm_consts.svh ***
// constants of the identification, status and input selector registers
// assumes: 8-bit registers behind a register read/write command port
`ifndef ADM_CONSTS_SVH
`define ADM_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets (5-bit address space of the whole configuration map)
`define ADM_ADDR_W          5
`define ADM_ADDR_IDENTITY   5'h00
`define ADM_ADDR_FLAGS      5'h01
`define ADM_ADDR_SELECTOR   5'h02

////////////////////////////////////////////////////////////////////////////////
// reset values
`define ADM_FLAGS_RESET     8'h80
`define ADM_SELECTOR_RESET  8'h01

////////////////////////////////////////////////////////////////////////////////
// field positions
`define ADM_MODEL_MSB       2
`define ADM_MODEL_LSB       0
`define ADM_RSVD_MSB        7
`define ADM_RSVD_LSB        3
`define ADM_POR_BIT         7
`define ADM_NOT_READY_BIT   6
`define ADM_RAIL_MSB        5
`define ADM_RAIL_LSB        2
`define ADM_THIRD_BIT       1
`define ADM_MISSING_BIT     0
`define ADM_POS_SEL_MSB     7
`define ADM_POS_SEL_LSB     4
`define ADM_NEG_SEL_MSB     3
`define ADM_NEG_SEL_LSB     0

////////////////////////////////////////////////////////////////////////////////
// input selector codes
`define ADM_LAST_AIN_CODE   4'hb
`define ADM_COMMON_CODE     4'hc

`endif

// *** hw/adm_pkg.sv ***
// types shared by the register bank and its monitor front end
// assumes: nothing beyond the constants header
package adm_pkg;

    // decoded form of one four-bit input selector field
    typedef struct packed {
        logic [11:0] ain_onehot;
        logic        common;
        logic        reserved;
    } adm_sel_dec_s;

    // whole state of the register bank
    typedef struct packed {
        logic         por_flag;
        logic [7:0]   selector;
        logic [7:0]   rd_data;
        logic         rd_valid;
        adm_sel_dec_s pos_dec;
        adm_sel_dec_s neg_dec;
    } adm_bank_s;

    // whole state of the monitor synchroniser
    typedef struct packed {
        logic [6:0] stage1;
        logic [6:0] stage2;
    } adm_sync_s;

endpackage : adm_pkg

// *** hw/adm_mon_if.sv ***
// carrier of the synchronised monitor flags, enable-gated except not_ready
// assumes: one clock domain on both sides
interface adm_mon_if;
    logic [3:0] rail_flags;
    logic       ref_below_third_flag;
    logic       ref_missing_flag;
    logic       not_ready;

    modport src (
        output rail_flags,
        output ref_below_third_flag,
        output ref_missing_flag,
        output not_ready
    );
    modport snk (
        input rail_flags,
        input ref_below_third_flag,
        input ref_missing_flag,
        input not_ready
    );
endinterface : adm_mon_if

// *** hw/adm_monitor_sync.sv ***
// synchroniser and enable gating for the analog monitor comparators
// assumes: comparator and start-up levels arrive asynchronously; enables come
// from registers on clock_in
module adm_monitor_sync
    import adm_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic [3:0] rail_near_in,
    input  wire logic       ref_below_third_in,
    input  wire logic       ref_missing_in,
    input  wire logic       startup_done_in,
    input  wire logic       rail_monitor_enable_in,
    input  wire logic [1:0] ref_monitor_enable_in,
    adm_mon_if.src          mon
);

    adm_sync_s st;
    adm_sync_s next_st;

    ////////////////////////////////////////////////////////////////////////////
    // two flops per level; stage1 feeds stage2 only
    always_comb begin
        next_st        = st;
        next_st.stage1 = {startup_done_in, rail_near_in, ref_below_third_in, ref_missing_in};
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gating: the comparators may toggle while disabled, flags must not
    always_comb begin
        mon.rail_flags           = rail_monitor_enable_in ? st.stage2[5:2] : 4'h0;
        mon.ref_below_third_flag = ref_monitor_enable_in[1] & st.stage2[1];
        mon.ref_missing_flag     = (|ref_monitor_enable_in) & st.stage2[0];
        mon.not_ready            = ~st.stage2[6];
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_rail_gate_off:
    assert property (!rail_monitor_enable_in |-> mon.rail_flags == 4'h0)
        else $error("rail flag shown while rail monitor disabled");

    a_ref_gate_off:
    assert property (ref_monitor_enable_in == 2'h0 |-> !mon.ref_missing_flag && !mon.ref_below_third_flag)
        else $error("reference flag shown while reference monitor disabled");

    a_missing_follows:
    assert property ((|ref_monitor_enable_in) && $past(reset_n_in, 3) && $past(ref_missing_in, 2)
                     |-> mon.ref_missing_flag)
        else $error("missing reference not reported two cycles after it appeared");

endmodule : adm_monitor_sync

// *** testbench/adm_host_model.sv ***
// host side of the register command port: issues register read and write commands
// assumes: one clock; a read answer appears at the request edge and stands for one cycle
`include "adm_consts.svh"

module adm_host_model (
    input  wire logic                   clock_in,
    output logic                        cmd_valid_out,
    output logic                        cmd_write_out,
    output logic [`ADM_ADDR_W-1:0]      cmd_addr_out,
    output logic [7:0]                  cmd_wdata_out,
    input  wire logic                   rd_valid_in,
    input  wire logic [7:0]             rd_data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid_out = 1'b0;
        cmd_write_out = 1'b0;
        cmd_addr_out  = '0;
        cmd_wdata_out = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // released lines go to their inverse, so late sampling never matches by luck
    task automatic issue(input logic wr, input logic [`ADM_ADDR_W-1:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        #1;
        cmd_valid_out = 1'b1;
        cmd_write_out = wr;
        cmd_addr_out  = addr;
        cmd_wdata_out = data;
        @(posedge clock_in);
        #1;
        cmd_valid_out = 1'b0;
        cmd_write_out = ~wr;
        cmd_addr_out  = ~addr;
        cmd_wdata_out = ~data;
    endtask : issue

    task automatic write_reg(input logic [`ADM_ADDR_W-1:0] addr, input logic [7:0] data);
        issue(1'b1, addr, data);
    endtask : write_reg

    // answer strobe stands one cycle, looked at right after the request edge
    task automatic read_reg(input logic [`ADM_ADDR_W-1:0] addr, output logic [7:0] data);
        issue(1'b0, addr, 8'h00);
        data = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
    endtask : read_reg
endmodule : adm_host_model

// *** testbench/tb_adm_id_status_mux_regs.sv ***
// self-checking bench of the identification, status and input selector bank
// assumes: host model on the command port; analog monitor levels driven here
`include "adm_consts.svh"

`define CHECK(name, exp, got) \
    compares++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    end

module tb_adm_id_status_mux_regs;
    import adm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [2:0] MODEL = 3'h5;  // arbitrary value
    logic        clock_in = 1'b0, reset_n_in = 1'b0, rd_valid, cmd_valid, cmd_write;
    logic [4:0]  cmd_addr;
    logic [7:0]  cmd_wdata, rd_data, d, first;
    logic [3:0]  rail_near = 4'h0, pos_sel, neg_sel;
    logic        third = 1'b0, missing = 1'b0, started = 1'b0, rail_en = 1'b0;
    logic [1:0]  ref_en = 2'h0;
    logic        por, pos_com, pos_rsv, neg_com, neg_rsv;
    logic [11:0] pos_hot, neg_hot;
    int          errors = 0, compares = 0, cycles = 0;

    adm_regs #(.MODEL_CODE(MODEL), .RESERVED_BITS(5'h0a)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .rail_near_in(rail_near), .ref_below_third_in(third),
        .ref_missing_in(missing), .startup_done_in(started), .rail_monitor_enable_in(rail_en),
        .ref_monitor_enable_in(ref_en), .power_on_event_flag_out(por), .positive_input_select_out(pos_sel),
        .negative_input_select_out(neg_sel), .positive_ain_onehot_out(pos_hot), .positive_common_out(pos_com),
        .positive_reserved_out(pos_rsv), .negative_ain_onehot_out(neg_hot), .negative_common_out(neg_com),
        .negative_reserved_out(neg_rsv));

    adm_host_model host (.clock_in(clock_in), .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
        .cmd_addr_out(cmd_addr), .cmd_wdata_out(cmd_wdata), .rd_valid_in(rd_valid), .rd_data_in(rd_data));

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : settle

    task automatic do_reset(input int n);
        @(posedge clock_in);
        #1;
        reset_n_in = 1'b0;
        settle(n);
        reset_n_in = 1'b1;
    endtask : do_reset

    // starts with start-up unfinished so the not-ready bit is seen both ways
    task automatic test_defaults();
        host.read_reg(`ADM_ADDR_FLAGS, d);
        `CHECK("flags at reset", 8'hc0, d)
        started = 1'b1;
        settle(3);
        host.read_reg(`ADM_ADDR_FLAGS, d);
        `CHECK("flags started", 8'h80, d)
        host.read_reg(`ADM_ADDR_SELECTOR, d);
        `CHECK("selector reset", 8'h01, d)
        `CHECK("pos onehot reset", 12'h001, pos_hot)
        `CHECK("neg onehot reset", 12'h002, neg_hot)
        $display("test defaults done");
    endtask : test_defaults

    // only the model code is judged; the reserved bits may differ by version
    task automatic test_identity();
        host.read_reg(`ADM_ADDR_IDENTITY, first);
        `CHECK("model code", MODEL, first[2:0])
        host.write_reg(`ADM_ADDR_IDENTITY, ~first);
        host.read_reg(`ADM_ADDR_IDENTITY, d);
        `CHECK("identity after write", first, d)
        host.write_reg(5'h03, 8'h5a);
        host.read_reg(5'h1f, d);
        `CHECK("unmapped read", 8'h00, d)
        $display("test identity done");
    endtask : test_identity

    task automatic test_por_flag();
        host.write_reg(`ADM_ADDR_FLAGS, 8'hff);
        `CHECK("por kept by ones", 1'b1, por)
        host.read_reg(`ADM_ADDR_FLAGS, d);
        `CHECK("flags after ro write", 8'h80, d)
        host.write_reg(`ADM_ADDR_FLAGS, 8'h00);
        `CHECK("por cleared", 1'b0, por)
        host.write_reg(`ADM_ADDR_FLAGS, 8'h80);
        host.read_reg(`ADM_ADDR_FLAGS, d);
        `CHECK("por not set by host", 8'h00, d)
        $display("test por flag done");
    endtask : test_por_flag

    // rail pattern 9 reads the same bit-reversed, so a swapped bit order would not show up
    task automatic test_monitors();
        logic [7:0] exp;
        rail_near = 4'h9;
        third = 1'b1;
        missing = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rail_en = i[2];
            ref_en = i[1:0];
            settle(3);
            exp = {2'b00, rail_en ? 4'h9 : 4'h0, ref_en[1], ref_en != 2'h0};
            host.read_reg(`ADM_ADDR_FLAGS, d);
            `CHECK("monitor flags", exp, d)
        end
        third = 1'b0;
        missing = 1'b0;
        rail_near = 4'h0;
        settle(3);
        host.read_reg(`ADM_ADDR_FLAGS, d);
        `CHECK("flags cleared", 8'h00, d)
        $display("test monitors done");
    endtask : test_monitors

    task automatic test_selector();
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            host.write_reg(`ADM_ADDR_SELECTOR, {c, ~c});
            `CHECK("pos onehot", (c < 4'hc) ? 12'h001 << c : 12'h000, pos_hot)
            `CHECK("neg onehot", (~c < 4'hc) ? 12'h001 << ~c : 12'h000, neg_hot)
            `CHECK("common flags", {c == 4'hc, ~c == 4'hc}, {pos_com, neg_com})
            `CHECK("reserved flags", {c > 4'hc, ~c > 4'hc}, {pos_rsv, neg_rsv})
            host.read_reg(`ADM_ADDR_SELECTOR, d);
            `CHECK("selector readback", {c, ~c}, d)
            `CHECK("select outputs", {c, ~c}, {pos_sel, neg_sel})
        end
        $display("test selector done");
    endtask : test_selector

    // a reset in mid-run brings back every default
    task automatic test_rereset();
        do_reset(3);
        `CHECK("por after reset", 1'b1, por)
        settle(3);
        host.read_reg(`ADM_ADDR_SELECTOR, d);
        `CHECK("selector after reset", 8'h01, d)
        host.read_reg(`ADM_ADDR_FLAGS, d);
        `CHECK("flags after reset", 8'h80, d)
        $display("test rereset done");
    endtask : test_rereset

    initial begin
        repeat (6) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        test_defaults();
        test_identity();
        test_por_flag();
        test_monitors();
        test_selector();
        test_rereset();
        finish_test();
    end
endmodule : tb_adm_id_status_mux_regs
